//--- core/uenc_ctrl.sv
/*
 Endpoint NAK control, bulk IN bank toggling, DMA requests, direct
 serial-engine controls and the read-clear auto-request flags.
 Assumes serial engine, DMA controller and CPU port share i_core_clk.
*/
// Notes on behaviour
// - Enabling DMA while bulk OUT2 CPU bank holds data raises request at once.
// - Bulk OUT DMA request drops when CPU-side bank is read empty.
// - DMA terminal count drops the endpoint DMA request.
// - Bulk IN send-enable bits, 1 sends, 0 NAKs, reset 0.
// - Send-enable clears only when engine bank is empty, sets on every toggle.
// - Toggle needs CPU bank full or data-end, and engine bank count zero.
// - Two 64-byte banks; engine bank kept until sent correctly.
// - DMA-filled bank without auto-toggle waits for data-end.
// - Data-end after last write toggles and sets send-enable together.
// - Clearing a bulk IN fifo forces its send-enable to 0.
// - After 64 DMA bytes request drops; returns on toggle unless masked.
// - Terminal count on bulk IN also masks that DMA request.
// - Gate register bits 3 and 2 pass bulk OUT NAK writes, reset 0.
// - Resume request is acted on only while the bus is suspended.
// - Auto-request flags set only after the status stage completes.
// - Reading a flag register clears all its flags.
// - Clear flags bits 6 to 1 report endpoints 0,1,2,3,4,7.
// - Clear flags bit 0 reports a device-directed clear.
// - Set flags: configuration bit 7, endpoint bit 2, device bit 0.
// - Endpoint clear flags read zero for endpoints not enabled.
// - Fifo clears show in the NAK register five clocks later.
// - Bulk OUT NAK bits take writes only while gated open.
module uenc_ctrl
    import uenc_pkg::*;
(
    // Clock and reset
    input  wire logic                i_core_clk,
    input  wire logic                i_arst_n,
    // Register port
    input  wire uenc_reg_req_t       i_reg,
    output logic [7:0]               o_reg_rdata,
    // Serial engine and fifo events
    input  wire uenc_in_evt_t        i_in_evt,
    input  wire logic                i_out2_cpu_avail,
    input  wire logic                i_setup_rcvd,
    input  wire logic                i_suspended,
    input  wire logic                i_resume_done,
    input  wire uenc_auto_evt_t      i_auto_evt,
    input  wire logic [N_CLR_EP-1:0] i_ep_enabled,
    // DMA controller
    input  wire logic [2:0]          i_dma_tc,
    output logic [N_IN-1:0]          o_in_dreq,
    output logic                     o_out2_dreq,
    // Serial engine controls
    output logic [N_IN-1:0]          o_in_send_en,
    output logic [1:0]               o_out_nak,
    output logic                     o_ep0_stall,
    output logic                     o_resume_req
);
    // =====================================================
    // State
    typedef struct packed {
        logic [1:0]                  nak_gate;
        logic                        stall;
        logic                        resume;
        logic [N_IN-1:0]             dend;
        logic [N_IN-1:0]             auto_tgl;
        logic [N_IN-1:0]             in_dma_en;
        logic [N_IN-1:0]             in_mask;
        logic                        out_dma_en;
        logic [N_CLR_EP:0]           clr_flg;
        logic [2:0]                  set_flg;
        logic [N_IN-1:0]             send_en;
        logic [1:0]                  out_nak;
        logic [N_IN-1:0][CNT_W-1:0]  cpu_cnt;
        logic [N_IN-1:0]             cpu_dma;
        logic [N_IN-1:0][CNT_W-1:0]  sie_cnt;
        logic [CLR_DELAY-1:0][N_IN-1:0] clr_pipe;
        logic [N_IN-1:0]             in_dreq;
        logic                        out_dreq;
        logic [7:0]                  rdata;
    } uenc_state_t;

    localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(BANK_BYTES);

    uenc_state_t st;
    uenc_state_t next_st;
    logic [N_IN-1:0] toggle;
    logic [N_IN-1:0] full;
    logic            wr_hit;
    logic            rd_hit;

    // =====================================================
    // Next state
    always_comb begin
        next_st = st;
        toggle  = '0;
        full    = '0;
        wr_hit  = i_reg.wr;
        rd_hit  = i_reg.rd;
        next_st.rdata = 8'h00;

        // Register writes
        if (wr_hit) begin
            case (i_reg.addr)
                OFS_NAK_GATE: begin
                    next_st.nak_gate = i_reg.wdata[POS_OUT2_NAK:POS_OUT1_NAK];
                end
                OFS_EP_NAK: begin
                    // Each OUT NAK bit is writable only through its gate
                    for (int b = 0; b < 2; b++) begin
                        if (st.nak_gate[b]) begin
                            next_st.out_nak[b] = i_reg.wdata[POS_OUT1_NAK+b];
                        end
                    end
                end
                OFS_SE_CTRL: begin
                    next_st.stall = i_reg.wdata[POS_STALL];
                    // Resume only meaningful while the bus is suspended
                    if (i_suspended && i_reg.wdata[POS_RESUME]) begin
                        next_st.resume = 1'b1;
                    end
                end
                OFS_DATA_END: begin
                    next_st.dend     = st.dend | i_reg.wdata[N_IN-1:0];
                    next_st.auto_tgl = i_reg.wdata[POS_AUTO_TGL+:N_IN];
                end
                OFS_DMA_CTRL: begin
                    next_st.in_dma_en  = i_reg.wdata[N_IN-1:0];
                    next_st.out_dma_en = i_reg.wdata[POS_OUT_DMA];
                    next_st.in_mask    = i_reg.wdata[POS_IN_MASK+:N_IN];
                end
                default: begin
                end
            endcase
        end

        // Resume request falls when engine reports it sent
        if (i_resume_done) begin
            next_st.resume = 1'b0;
        end
        // A SETUP token releases the stall
        if (i_setup_rcvd) begin
            next_st.stall = 1'b0;
        end

        // Fifo clear delay line; hazard of reading stale status is the
        // firmware's to avoid by spacing accesses
        next_st.clr_pipe = {st.clr_pipe[CLR_DELAY-2:0],
                            (wr_hit && i_reg.addr == OFS_FIFO_CLR) ?
                            i_reg.wdata[N_IN-1:0] : {N_IN{1'b0}}};

        // Bulk IN endpoints
        for (int e = 0; e < N_IN; e++) begin
            full[e] = (st.cpu_cnt[e] == FULL_CNT);
            if (i_in_evt.wr[e] && !full[e]) begin
                next_st.cpu_cnt[e] = st.cpu_cnt[e] + CNT_W'(1);
                next_st.cpu_dma[e] = i_in_evt.wr_dma[e];
            end
            // Engine bank held until sent correctly
            if (i_in_evt.tx_ok[e]) begin
                next_st.sie_cnt[e] = '0;
                next_st.send_en[e] = 1'b0;
            end
            // Toggle: CPU bank complete and engine bank empty
            toggle[e] = (st.sie_cnt[e] == '0) && !st.send_en[e] &&
                        ((full[e] && (st.auto_tgl[e] || !st.cpu_dma[e])) ||
                         st.dend[e]);
            if (toggle[e]) begin
                next_st.sie_cnt[e] = st.cpu_cnt[e];
                next_st.cpu_cnt[e] = '0;
                next_st.cpu_dma[e] = 1'b0;
                next_st.dend[e]    = 1'b0;
                next_st.send_en[e] = 1'b1;
            end
            // Terminal count masks the request
            if (i_dma_tc[e]) begin
                next_st.in_mask[e] = 1'b1;
            end
            // Fifo clear wins over every other update
            if (st.clr_pipe[CLR_DELAY-1][e]) begin
                next_st.cpu_cnt[e] = '0;
                next_st.sie_cnt[e] = '0;
                next_st.dend[e]    = 1'b0;
                next_st.cpu_dma[e] = 1'b0;
                next_st.send_en[e] = 1'b0;
            end
            // Request while room remains; a toggle empties the bank again
            next_st.in_dreq[e] = next_st.in_dma_en[e] && !next_st.in_mask[e] &&
                                 (next_st.cpu_cnt[e] != FULL_CNT) &&
                                 !i_dma_tc[e];
        end

        // Bulk OUT2 DMA request
        if (i_dma_tc[2]) begin
            next_st.out_dma_en = 1'b0;
        end
        next_st.out_dreq = next_st.out_dma_en && i_out2_cpu_avail &&
                           !i_dma_tc[2];

        // Reads, with read-clear where the flag set wins
        if (rd_hit) begin
            case (i_reg.addr)
                OFS_EP_NAK: begin
                    next_st.rdata = {4'h0, st.out_nak, st.send_en};
                end
                OFS_NAK_GATE: begin
                    next_st.rdata = {4'h0, st.nak_gate, 2'h0};
                end
                OFS_SE_CTRL: begin
                    next_st.rdata = {4'h0, st.stall, 2'h0, st.resume};
                end
                OFS_CLR_FLG: begin
                    next_st.rdata = {1'b0, st.clr_flg[N_CLR_EP:1] & i_ep_enabled,
                                     st.clr_flg[0]};
                    next_st.clr_flg = '0;
                end
                OFS_SET_FLG: begin
                    next_st.rdata = {st.set_flg[2], 4'h0, st.set_flg[1], 1'b0,
                                     st.set_flg[0]};
                    next_st.set_flg = '0;
                end
                OFS_DATA_END: begin
                    next_st.rdata = {2'h0, st.auto_tgl, 2'h0, st.dend};
                end
                OFS_DMA_CTRL: begin
                    next_st.rdata = {2'h0, st.in_mask, 1'b0, st.out_dma_en,
                                     st.in_dma_en};
                end
                default: begin
                    next_st.rdata = 8'h00;
                end
            endcase
        end

        // Status-stage completion events
        next_st.clr_flg = next_st.clr_flg |
                          {i_auto_evt.clr_ep, i_auto_evt.clr_dev};
        next_st.set_flg = next_st.set_flg |
                          {i_auto_evt.set_cfg, i_auto_evt.set_ep,
                           i_auto_evt.set_dev};
    end

    // =====================================================
    // State register
    always_ff @(posedge i_core_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // Outputs straight from state flops
    assign o_reg_rdata  = st.rdata;
    assign o_in_dreq    = st.in_dreq;
    assign o_out2_dreq  = st.out_dreq;
    assign o_in_send_en = st.send_en;
    assign o_out_nak    = st.out_nak;
    assign o_ep0_stall  = st.stall;
    assign o_resume_req = st.resume;

    // =====================================================
    // Checks
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (!i_arst_n);

    a_gate_blocks_nak: assert property (
        i_reg.wr && i_reg.addr == OFS_EP_NAK && !st.nak_gate[0]
        |=> $stable(st.out_nak[0]))
        else $error("gated OUT NAK bit changed");
    a_gate_reg_load: assert property (
        i_reg.wr && i_reg.addr == OFS_NAK_GATE
        |=> st.nak_gate == $past(i_reg.wdata[3:2]))
        else $error("gate register not loaded");
    a_toggle_sets_send: assert property (
        toggle[0] && !st.clr_pipe[CLR_DELAY-1][0]
        |=> o_in_send_en[0] && st.cpu_cnt[0] == '0)
        else $error("toggle without send enable");
    a_toggle_needs_empty: assert property (
        $rose(o_in_send_en[1]) |-> $past(st.sie_cnt[1]) == '0)
        else $error("toggle with engine bank busy");
    a_dma_full_wait: assert property (
        full[0] && st.cpu_dma[0] && !st.auto_tgl[0] && !st.dend[0]
        |-> !toggle[0])
        else $error("DMA bank toggled without data end");
    a_clear_delay: assert property (
        i_reg.wr && i_reg.addr == OFS_FIFO_CLR && i_reg.wdata[1]
        |=> ##5 !o_in_send_en[1])
        else $error("fifo clear not seen five clocks on");
    a_tc_masks_in: assert property (
        i_dma_tc[1] |=> !o_in_dreq[1] && st.in_mask[1])
        else $error("terminal count did not mask");
    a_full_drops_req: assert property (
        full[0] |=> !o_in_dreq[0] || $past(toggle[0]) ||
                    $past(st.clr_pipe[CLR_DELAY-1][0]))
        else $error("request held on full bank");
    a_out_req_avail: assert property (
        !i_out2_cpu_avail |=> !o_out2_dreq)
        else $error("OUT request with empty bank");
    a_out_req_rise: assert property (
        i_reg.wr && i_reg.addr == OFS_DMA_CTRL && i_reg.wdata[2] &&
        i_out2_cpu_avail && !i_dma_tc[2] |=> o_out2_dreq)
        else $error("OUT request not raised at once");
    a_read_clears: assert property (
        i_reg.rd && i_reg.addr == OFS_SET_FLG && !i_auto_evt.set_cfg
        |=> !st.set_flg[2])
        else $error("set flags not cleared by read");
    a_flag_set_wins: assert property (
        i_auto_evt.clr_dev |=> st.clr_flg[0])
        else $error("clear event lost");
    a_stall_out: assert property (
        i_reg.wr && i_reg.addr == OFS_SE_CTRL && i_reg.wdata[3] && !i_setup_rcvd
        |=> o_ep0_stall)
        else $error("stall not driven");

    // Gate, resume and terminal count checks
    a_gate_open_write: assert property (
        i_reg.wr && i_reg.addr == OFS_EP_NAK && st.nak_gate[1]
        |=> o_out_nak[1] == $past(i_reg.wdata[3]))
        else $error("open gate dropped OUT NAK write");
    a_resume_gated: assert property (
        i_reg.wr && i_reg.addr == OFS_SE_CTRL && !i_suspended && !st.resume
        |=> !o_resume_req)
        else $error("resume raised while not suspended");
    a_out_tc_drop: assert property (
        i_dma_tc[2] |=> !o_out2_dreq && !st.out_dma_en)
        else $error("OUT request held after terminal count");
    a_in_tc_drop: assert property (
        i_dma_tc[0] |=> !o_in_dreq[0])
        else $error("IN request held after terminal count");

    // Event flag checks; a set beside a read-clear must survive
    a_set_flag_wins: assert property (
        i_reg.rd && i_reg.addr == OFS_SET_FLG && i_auto_evt.set_dev
        |=> st.set_flg[0])
        else $error("set event lost to read clear");
    a_clr_ep_map: assert property (
        i_auto_evt.clr_ep[5] |=> st.clr_flg[6])
        else $error("top endpoint clear flag lost");
    a_set_cfg_map: assert property (
        i_auto_evt.set_cfg |=> st.set_flg[2])
        else $error("configuration flag lost");

    // Bank hold, data-end and fifo clear checks
    a_bank_held: assert property (
        o_in_send_en[0] && !i_in_evt.tx_ok[0] && !st.clr_pipe[CLR_DELAY-1][0]
        |=> o_in_send_en[0])
        else $error("engine bank dropped before sent");
    a_dend_toggles: assert property (
        st.dend[0] && st.sie_cnt[0] == '0 && !st.send_en[0] &&
        !st.clr_pipe[CLR_DELAY-1][0] |=> o_in_send_en[0])
        else $error("data end did not toggle");
    a_clear_forces_nak: assert property (
        st.clr_pipe[CLR_DELAY-1][1] |=> !o_in_send_en[1] && st.cpu_cnt[1] == '0)
        else $error("fifo clear left send enable");
    a_sent_clears_send: assert property (
        i_in_evt.tx_ok[1] |=> !o_in_send_en[1])
        else $error("send enable held after bank sent");

    c_toggle_in: cover property (toggle[0] ##[1:200] i_in_evt.tx_ok[0]);
    c_dend_short: cover property (st.dend[1] && !full[1] ##1 o_in_send_en[1]);
    c_tc_in: cover property (o_in_dreq[0] ##1 i_dma_tc[0]);
    c_flag_read: cover property (i_reg.rd && i_reg.addr == OFS_CLR_FLG
                                 && st.clr_flg != '0);
    c_out_tc: cover property (o_out2_dreq ##1 i_dma_tc[2]);
endmodule : uenc_ctrl

//--- core/uenc_pkg.sv
/*
 Shared constants and carriers for the endpoint NAK and DMA request block.
 Assumes one core clock and a plain register port with byte-wide data.
*/
package uenc_pkg;
    // =====================================================
    // Register offsets
    localparam logic [31:0] OFS_EP_NAK   = 32'h0020_0004;
    localparam logic [31:0] OFS_NAK_GATE = 32'h0020_0006;
    localparam logic [31:0] OFS_SE_CTRL  = 32'h0020_0008;
    localparam logic [31:0] OFS_CLR_FLG  = 32'h0020_000A;
    localparam logic [31:0] OFS_SET_FLG  = 32'h0020_000C;
    localparam logic [31:0] OFS_DATA_END = 32'h0020_0030;
    localparam logic [31:0] OFS_DMA_CTRL = 32'h0020_0032;
    localparam logic [31:0] OFS_FIFO_CLR = 32'h0020_0034;
    // =====================================================
    // Field positions
    localparam int POS_OUT1_NAK  = 2;
    localparam int POS_OUT2_NAK  = 3;
    localparam int POS_STALL     = 3;
    localparam int POS_RESUME    = 0;
    localparam int POS_SET_CFG   = 7;
    localparam int POS_SET_EP    = 2;
    localparam int POS_SET_DEV   = 0;
    localparam int POS_AUTO_TGL  = 4;
    localparam int POS_OUT_DMA   = 2;
    localparam int POS_IN_MASK   = 4;
    // =====================================================
    // Reset values and sizes
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam int BANK_BYTES       = 64;
    localparam int CNT_W            = 7;
    localparam int N_IN             = 2;
    localparam int N_CLR_EP         = 6;
    // Fifo clear reaches the NAK view this many core clocks later
    localparam int CLR_DELAY        = 5;
    // =====================================================
    // Carriers
    typedef struct packed {
        logic [31:0] addr;
        logic [7:0]  wdata;
        logic        wr;
        logic        rd;
    } uenc_reg_req_t;

    typedef struct packed {
        logic [N_IN-1:0] wr;      // CPU side byte written
        logic [N_IN-1:0] wr_dma;  // Byte came from DMA
        logic [N_IN-1:0] tx_ok;   // Serial engine sent bank correctly
    } uenc_in_evt_t;

    typedef struct packed {
        logic [N_CLR_EP-1:0] clr_ep;
        logic                clr_dev;
        logic                set_cfg;
        logic                set_ep;
        logic                set_dev;
    } uenc_auto_evt_t;
endpackage : uenc_pkg

//--- tb/tb_top.sv
/*
 Self-checking bench for uenc_ctrl with the far-side model.
 Assumes package and model compiled first; one 250 MHz clock.
*/
module tb_top
    import uenc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // =========================================
    // Stimulus and observed signals
    logic            i_core_clk = 1'b0;
    logic            i_arst_n   = 1'b0;
    uenc_reg_req_t   req        = '0;
    uenc_auto_evt_t  auto_evt   = '0;
    uenc_in_evt_t    evt;
    logic [N_IN-1:0] tb_wr      = '0;
    logic [N_IN-1:0] dma_go     = '0;
    logic [5:0]      ep_en      = '0;
    logic [2:0]      tc         = '0;
    logic            slow       = 1'b0;
    logic            avail      = 1'b0;
    logic            setup      = 1'b0;
    logic            susp       = 1'b0;
    logic            rdone      = 1'b0;
    logic            rd_d       = 1'b0;
    logic [N_IN-1:0] far_wr, far_tx, dreq, send_en;
    logic [7:0]      rdata;
    logic [1:0]      out_nak;
    logic            out2_dreq, stall, resume;
    logic [7:0]      expq [$];
    int              fails       = 0;
    int              comparisons = 0;
    assign evt = '{wr: tb_wr | far_wr, wr_dma: far_wr, tx_ok: far_tx};
    always #2 i_core_clk = ~i_core_clk;
    // =========================================
    // Block and far side
    uenc_ctrl dut_u (
        .i_core_clk      (i_core_clk),
        .i_arst_n        (i_arst_n),
        .i_reg           (req),
        .o_reg_rdata     (rdata),
        .i_in_evt        (evt),
        .i_out2_cpu_avail(avail),
        .i_setup_rcvd    (setup),
        .i_suspended     (susp),
        .i_resume_done   (rdone),
        .i_auto_evt      (auto_evt),
        .i_ep_enabled    (ep_en),
        .i_dma_tc        (tc),
        .o_in_dreq       (dreq),
        .o_out2_dreq     (out2_dreq),
        .o_in_send_en    (send_en),
        .o_out_nak       (out_nak),
        .o_ep0_stall     (stall),
        .o_resume_req    (resume)
    );
    uenc_far_model far_u (
        .i_core_clk(i_core_clk),
        .i_arst_n  (i_arst_n),
        .i_slow    (slow),
        .i_dma_go  (dma_go),
        .i_send_en (send_en),
        .i_dreq    (dreq),
        .o_tx_ok   (far_tx),
        .o_dma_wr  (far_wr)
    );
    // =========================================
    // Checking and closing
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic end_of_test();
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_of_test
    // Read data stand one cycle only; the oldest note is due then
    always @(posedge i_core_clk) begin
        rd_d <= req.rd;
        if (rd_d) begin
            chk(rdata, expq.pop_front());
        end
    end
    // =========================================
    // Bus cycles and waits; each task ends just after a clock edge
    task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge i_core_clk);
        req.wr <= 1'b0;
        @(posedge i_core_clk);
    endtask : wr_reg
    task automatic rd_reg(input logic [31:0] a, input logic [7:0] e);
        expq.push_back(e);
        req <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge i_core_clk);
        req.rd <= 1'b0;
        @(posedge i_core_clk);
    endtask : rd_reg
    function automatic logic obs(input int s);
        case (s)
            0, 1: return send_en[s];
            2: return dreq[0];
            3: return dreq[1];
            4: return out2_dreq;
            5: return stall;
            default: return resume;
        endcase
    endfunction : obs
    // Bounded wait; running out counts a mismatch and ends the run
    task automatic wait_obs(input int s, input logic v, input int lim, output int n);
        n = 0;
        while (obs(s) !== v && n < lim) begin
            @(posedge i_core_clk);
            n++;
        end
        chk(obs(s), v);
        if (obs(s) !== v) end_of_test();
    endtask : wait_obs
    task automatic hold_obs(input int s, input logic v, input int cyc);
        repeat (cyc) begin
            @(posedge i_core_clk);
            chk(obs(s), v);
        end
    endtask : hold_obs
    task automatic wr_bytes(input int e, input int cnt);
        tb_wr[e] <= 1'b1;
        repeat (cnt) @(posedge i_core_clk);
        tb_wr[e] <= 1'b0;
        @(posedge i_core_clk);
    endtask : wr_bytes
    // =========================================
    // Main sequence
    initial begin
        int n;
        logic [5:0] m;
        logic [5:0] f;
        logic [2:0] s;
        logic [31:0] regs [9];
        regs = '{OFS_EP_NAK, OFS_NAK_GATE, OFS_SE_CTRL, OFS_CLR_FLG, OFS_SET_FLG,
                 OFS_DATA_END, OFS_DMA_CTRL, OFS_FIFO_CLR, 32'h0020_0002};
        n = $urandom(21903);
        repeat (8) @(posedge i_core_clk);
        i_arst_n <= 1'b1;
        @(posedge i_core_clk);
        foreach (regs[i]) rd_reg(regs[i], RST_REG8);
        // Bulk OUT NAK writes pass only through an open gate
        wr_reg(OFS_EP_NAK, 8'h0C);
        rd_reg(OFS_EP_NAK, 8'h00);
        wr_reg(OFS_NAK_GATE, 8'h04);
        rd_reg(OFS_NAK_GATE, 8'h04);
        wr_reg(OFS_EP_NAK, 8'h0C);
        rd_reg(OFS_EP_NAK, 8'h04);
        wr_reg(OFS_NAK_GATE, 8'h0C);
        wr_reg(OFS_EP_NAK, 8'h08);
        rd_reg(OFS_EP_NAK, 8'h08);
        chk(out_nak, 2'h2);
        // Auto-request flags, random targets and enables, cleared by reading
        for (int k = 0; k < 2; k++) begin
            m = 6'($urandom);
            f = 6'($urandom);
            s = 3'($urandom);
            rd_reg(OFS_CLR_FLG, 8'h00);
            ep_en <= m;
            auto_evt <= {f, 1'b1, s};
            @(posedge i_core_clk);
            auto_evt <= '0;
            @(posedge i_core_clk);
            rd_reg(OFS_CLR_FLG, {1'b0, f & m, 1'b1});
            rd_reg(OFS_SET_FLG, {s[2], 4'h0, s[1], 1'b0, s[0]});
            rd_reg(OFS_SET_FLG, 8'h00);
        end
        // Stall until a setup; resume only while suspended
        wr_reg(OFS_SE_CTRL, 8'h08);
        wait_obs(5, 1'b1, 3, n);
        setup <= 1'b1;
        @(posedge i_core_clk);
        setup <= 1'b0;
        wait_obs(5, 1'b0, 3, n);
        wr_reg(OFS_SE_CTRL, 8'h01);
        hold_obs(6, 1'b0, 4);
        susp <= 1'b1;
        wr_reg(OFS_SE_CTRL, 8'h01);
        wait_obs(6, 1'b1, 3, n);
        rdone <= 1'b1;
        @(posedge i_core_clk);
        rdone <= 1'b0;
        wait_obs(6, 1'b0, 3, n);
        // IN2 two banks back to back with a slow host, then cleared
        slow <= 1'b1;
        wr_bytes(1, BANK_BYTES);
        wait_obs(1, 1'b1, 4, n);
        wr_bytes(1, BANK_BYTES);
        chk(send_en[1], 1'b1);
        wait_obs(1, 1'b0, 100, n);
        wait_obs(1, 1'b1, 4, n);
        wr_reg(OFS_FIFO_CLR, 8'h02);
        wait_obs(1, 1'b0, 12, n);
        chk(8'(n), 8'(CLR_DELAY));
        // IN1 short packet closed by data-end
        slow <= 1'b0;
        wr_bytes(0, 1 + $urandom_range(62));
        hold_obs(0, 1'b0, 3);
        wr_reg(OFS_DATA_END, 8'h01);
        wait_obs(0, 1'b1, 3, n);
        wait_obs(0, 1'b0, 10, n);
        // IN1 DMA bank, no auto toggle, terminal count mid-burst
        wr_reg(OFS_DMA_CTRL, 8'h01);
        wait_obs(2, 1'b1, 3, n);
        dma_go <= 2'h1;
        wait_obs(2, 1'b0, 80, n);
        hold_obs(0, 1'b0, 20);
        wr_reg(OFS_DATA_END, 8'h01);
        wait_obs(0, 1'b1, 3, n);
        wait_obs(2, 1'b1, 3, n);
        slow <= 1'b1;
        tc <= 3'h1;
        @(posedge i_core_clk);
        tc <= 3'h0;
        wait_obs(2, 1'b0, 3, n);
        dma_go <= 2'h0;
        hold_obs(2, 1'b0, 5);
        rd_reg(OFS_DMA_CTRL, 8'h11);
        wr_reg(OFS_DMA_CTRL, 8'h01);
        wait_obs(2, 1'b1, 3, n);
        // IN2 DMA request, then terminal count masks it
        wr_reg(OFS_DMA_CTRL, 8'h02);
        wait_obs(3, 1'b1, 3, n);
        tc <= 3'h2;
        @(posedge i_core_clk);
        tc <= 3'h0;
        wait_obs(3, 1'b0, 3, n);
        rd_reg(OFS_DMA_CTRL, 8'h22);
        // OUT2 DMA request follows the CPU bank and terminal count
        avail <= 1'b1;
        wr_reg(OFS_DMA_CTRL, 8'h04);
        wait_obs(4, 1'b1, 3, n);
        avail <= 1'b0;
        wait_obs(4, 1'b0, 3, n);
        avail <= 1'b1;
        wait_obs(4, 1'b1, 3, n);
        tc <= 3'h4;
        @(posedge i_core_clk);
        tc <= 3'h0;
        wait_obs(4, 1'b0, 3, n);
        hold_obs(4, 1'b0, 5);
        end_of_test();
    end
endmodule : tb_top

//--- tb/uenc_far_model.sv
/*
 Far side of the block: serial engine sending toggled IN banks, DMA filling them.
 Assumes the bench drives i_slow and i_dma_go by non-blocking assignment.
*/
module uenc_far_model
    import uenc_pkg::*;
(
    // Clock and reset
    input  wire logic            i_core_clk,
    input  wire logic            i_arst_n,
    // Bench controls and block requests
    input  wire logic            i_slow,
    input  wire logic [N_IN-1:0] i_dma_go,
    input  wire logic [N_IN-1:0] i_send_en,
    input  wire logic [N_IN-1:0] i_dreq,
    // Events into the block
    output logic [N_IN-1:0]      o_tx_ok,
    output logic [N_IN-1:0]      o_dma_wr
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] tx_cnt [N_IN];
    logic [6:0] dma_cnt [N_IN];
    logic       phase;
    // =========================================
    // Host takes 3 or 100 cycles; DMA stops itself after one bank
    always @(posedge i_core_clk or negedge i_arst_n) begin : far_seq
        logic w;
        if (!i_arst_n) begin
            o_tx_ok  <= '0;
            o_dma_wr <= '0;
            phase    <= 1'b0;
            tx_cnt   <= '{default: '0};
            dma_cnt  <= '{default: '0};
        end else begin
            phase <= ~phase;
            for (int e = 0; e < N_IN; e++) begin
                // Report a sent bank once, only while it is still offered
                o_tx_ok[e] <= i_send_en[e] && tx_cnt[e] == (i_slow ? 8'h64 : 8'h03);
                tx_cnt[e]  <= i_send_en[e] ? tx_cnt[e] + {7'h00, tx_cnt[e] != 8'hFF} : 8'h00;
                // Slow DMA writes every other cycle
                w = i_dma_go[e] && i_dreq[e] && dma_cnt[e] < 7'h40 && (!i_slow || phase);
                o_dma_wr[e] <= w;
                dma_cnt[e]  <= i_dreq[e] ? dma_cnt[e] + {6'h00, w} : 7'h00;
            end
        end
    end
endmodule : uenc_far_model
